/* File: pkg/bpa_cfg.svh */
`ifndef BPA_CFG_SVH
`define BPA_CFG_SVH

// register addresses on the request line (4-bit address field)
`define BPA_ADDR_NODE 4'h0
`define BPA_ADDR_CTRL 4'h1
`define BPA_ADDR_RSVD 4'h3
`define BPA_ADDR_PRIO 4'h4

// field positions and widths
`define BPA_NODE_W 6
`define BPA_PRIO_W 4
`define BPA_CTRL_INHIBIT_BIT 0
`define BPA_CTRL_RESET_BIT 1

// reset values
`define BPA_NODE_RST 6'h00
`define BPA_PRIO_RST 4'h0

// request frame lengths in bits, start and stop included
`define BPA_READ_LEN 5'h09
`define BPA_WRITE_LEN 5'h11
`define BPA_BUSREQ_LEN 5'h0B

// request type codes in the 3-bit type field
`define BPA_REQ_READ 3'h1
`define BPA_REQ_WRITE 3'h5

// arbitration bit period and bus reset length
`define BPA_CLK_NS 5
`define BPA_ARB_BIT_NS 20
`define BPA_ARB_BIT_CYC (`BPA_ARB_BIT_NS / `BPA_CLK_NS)
`define BPA_RESET_NS 200
`define BPA_RESET_CYC (`BPA_RESET_NS / `BPA_CLK_NS)

// ds encoder: one symbol every two clocks keeps toggling at half the bit rate
`define BPA_DS_DIV 2

`endif

/* File: pkg/bpa_pkg.sv */
package bpa_pkg;
  typedef enum logic [1:0] {
    BPA_REQ_IDLE,
    BPA_REQ_SHIFT
  } bpa_req_state_t;
  typedef enum logic [1:0] {
    BPA_ARB_IDLE,
    BPA_ARB_RUN,
    BPA_ARB_WON,
    BPA_ARB_LOST
  } bpa_arb_state_t;
  typedef logic [3:0] bpa_prio_t;
  typedef logic [5:0] bpa_node_t;
endpackage

/* File: design/bpa_arbiter.sv */
`timescale 1ns/100ps
`include "bpa_cfg.svh"

module bpa_arbiter (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire bpa_pkg::bpa_prio_t prio_in,
  input wire bpa_pkg::bpa_node_t node_in,
  input wire logic bus_sense_in,
  output logic drive_out,
  output logic busy_out,
  output logic won_out,
  output logic lost_out
);
  import bpa_pkg::*;

  localparam int BITS = `BPA_PRIO_W + `BPA_NODE_W;

  bpa_arb_state_t state;
  logic [BITS-1:0] code;
  logic [3:0] bit_cnt;
  logic [7:0] per_cnt;

  wire period_end = (per_cnt == 8'(`BPA_ARB_BIT_CYC - 1));
  wire my_bit = code[BITS-1];
  wire last_bit = (bit_cnt == 4'(BITS - 1));
  wire mismatch = (bus_sense_in != my_bit);

  // drive 1 asserts the wired-or line, 0 releases it
  assign drive_out = (state == BPA_ARB_RUN) && my_bit;
  assign busy_out = (state == BPA_ARB_RUN);
  assign won_out = (state == BPA_ARB_WON);
  assign lost_out = (state == BPA_ARB_LOST);

  // ************************************************************
  // bit-serial contention: priority then node number, msb first
  // ************************************************************
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= BPA_ARB_IDLE;
      code <= '0;
      bit_cnt <= 4'h0;
      per_cnt <= 8'h00;
    end else begin
      case (state)
        BPA_ARB_IDLE, BPA_ARB_WON, BPA_ARB_LOST: begin
          if (start_in) begin
            state <= BPA_ARB_RUN;
            code <= {prio_in, node_in};
            bit_cnt <= 4'h0;
            per_cnt <= 8'h00;
          end
        end
        BPA_ARB_RUN: begin
          per_cnt <= period_end ? 8'h00 : per_cnt + 8'h01;
          if (period_end) begin
            if (mismatch) begin
              state <= BPA_ARB_LOST;
            end else if (my_bit || last_bit) begin
              state <= BPA_ARB_WON;
            end else begin
              code <= {code[BITS-2:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        default: state <= BPA_ARB_IDLE;
      endcase
    end
  end

  // once out of contention the line is left released
  drop_out_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (busy_out && period_end && mismatch) |=> (!drive_out && !busy_out)) else $error("driving after loss");
  win_readback_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (busy_out && period_end && my_bit && bus_sense_in) |=> won_out)
    else $error("first 1 read back did not win");
  mismatch_lose_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (busy_out && period_end && mismatch) |=> lost_out) else $error("mismatch ignored");
  first_bit_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (!busy_out && start_in) |=> (drive_out == $past(prio_in[3])))
    else $error("priority msb not sent first");
endmodule

/* File: design/bpa_phy_regs.sv */
`timescale 1ns/100ps
`include "bpa_cfg.svh"

// What this block does
// - six-bit node address register, read/write, zero after reset
// - driver inhibit bit switches off transmit data and strobe drivers
// - link sets bus reset request; block clears it when reset completes
// - four-bit priority register; larger value wins arbitration
// - node at 0, inhibit/reset at 1 bits 0-1, priority at 4
// - output 1 asserts backplane, 0 releases it; wired-or combining
// - arbitration sends priority code then node number, one bit per period
// - sample bus each period; mismatch withdraws and stops driving
// - first node to drive and read back a 1 wins
// - data and strobe toggle no faster than half the bit rate
// - priority select pin takes priority from the four priority pins
// - requests on link line: read 9 bits, write 17, start 1, stop 0
module bpa_phy_regs (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic link_request_line_in,
  output logic read_valid_out,
  output logic [3:0] read_addr_out,
  output logic [7:0] read_data_out,
  input wire logic pin_priority_select_in,
  input wire logic [3:0] pin_priority_value_in,
  input wire logic tx_valid_in,
  input wire logic tx_bit_in,
  input wire logic bus_sense_in,
  output logic bus_drive_out,
  output logic tx_serial_data_out,
  output logic tx_serial_strobe_out,
  output logic tx_driver_en_out,
  output logic bus_reset_active_out,
  output logic arb_busy_out,
  output logic arb_won_out,
  output logic arb_lost_out
);
  import bpa_pkg::*;

  // ************************************************************
  // reset release and input synchronisers
  // ************************************************************
  logic rst_meta, rst_sync;
  logic link_request_line_meta, link_request_line_sync;
  logic psel_meta, psel_sync;
  logic [3:0] pval_meta, pval_sync;
  logic sense_meta, sense_sync;

  // reset leaves through two flops so every register wakes on the same edge
  // the raw reset still asserts at once, without waiting for a clock
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // request line, priority pins and bus sense pass two flops before use
  always_ff @(posedge sys_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      link_request_line_meta <= 1'b0;
      link_request_line_sync <= 1'b0;
      psel_meta <= 1'b0;
      psel_sync <= 1'b0;
      pval_meta <= 4'h0;
      pval_sync <= 4'h0;
      sense_meta <= 1'b0;
      sense_sync <= 1'b0;
    end else begin
      link_request_line_meta <= link_request_line_in;
      link_request_line_sync <= link_request_line_meta;
      psel_meta <= pin_priority_select_in;
      psel_sync <= psel_meta;
      pval_meta <= pin_priority_value_in;
      pval_sync <= pval_meta;
      sense_meta <= bus_sense_in;
      sense_sync <= sense_meta;
    end
  end

  // ************************************************************
  // serial request receiver on the link request line
  // ************************************************************
  bpa_req_state_t req_state;
  logic [15:0] req_shift;
  logic [4:0] req_cnt;
  logic [4:0] req_len;

  // type field sits right after the start bit; shift holds bits msb first
  wire [2:0] req_type = req_shift[2:0];
  wire [4:0] next_req_cnt = req_cnt + 5'h01;
  wire type_known = (req_cnt == 5'h04);
  wire frame_end = (req_state == BPA_REQ_SHIFT) && (next_req_cnt == req_len);
  wire stop_ok = frame_end && !link_request_line_sync;
  wire is_write = (req_len == `BPA_WRITE_LEN);
  wire is_read = (req_len == `BPA_READ_LEN);
  // read: start,type[3],addr[4],stop; write adds data[8]
  wire [3:0] rd_addr = req_shift[3:0];
  wire [3:0] wr_addr = req_shift[11:8];
  wire [7:0] wr_data = req_shift[7:0];

  // frame receiver: the length is fixed once the three type bits are in
  // a stop bit that reads 1 drops the whole frame: no write, no read, no arbitration
  // unknown type codes are taken as bus requests
  always_ff @(posedge sys_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      req_state <= BPA_REQ_IDLE;
      req_shift <= 16'h0000;
      req_cnt <= 5'h00;
      req_len <= `BPA_BUSREQ_LEN;
    end else begin
      case (req_state)
        BPA_REQ_IDLE: begin
          if (link_request_line_sync) begin // start bit
            req_state <= BPA_REQ_SHIFT;
            req_cnt <= 5'h01;
            req_shift <= 16'h0000;
            req_len <= `BPA_BUSREQ_LEN;
          end
        end
        BPA_REQ_SHIFT: begin
          req_cnt <= next_req_cnt;
          if (frame_end) begin
            req_state <= BPA_REQ_IDLE;
          end else begin
            req_shift <= {req_shift[14:0], link_request_line_sync};
          end
          if (type_known) begin
            req_len <= (req_type == `BPA_REQ_READ) ? `BPA_READ_LEN :
                       (req_type == `BPA_REQ_WRITE) ? `BPA_WRITE_LEN : `BPA_BUSREQ_LEN;
          end
        end
        default: req_state <= BPA_REQ_IDLE;
      endcase
    end
  end

  wire wr_stb = stop_ok && is_write;
  wire rd_stb = stop_ok && is_read;

  // ************************************************************
  // register file
  // ************************************************************
  bpa_node_t node_address;
  logic driver_inhibit;
  logic bus_reset_request;
  bpa_prio_t node_priority;
  logic [7:0] reset_cnt;

  wire wr_node = wr_stb && (wr_addr == `BPA_ADDR_NODE);
  wire wr_ctrl = wr_stb && (wr_addr == `BPA_ADDR_CTRL);
  wire wr_prio = wr_stb && (wr_addr == `BPA_ADDR_PRIO);
  wire reset_done = bus_reset_request && (reset_cnt == 8'(`BPA_RESET_CYC - 1));
  // a new request written as reset finishes wins over the self-clear
  wire next_reset_req = (wr_ctrl && wr_data[`BPA_CTRL_RESET_BIT]) ? 1'b1 :
                        reset_done ? 1'b0 : bus_reset_request;

  // register writes land on the stop-bit sample, so a cut frame changes nothing
  // data bits outside a field are dropped here, which keeps reserved bits at zero
  // reset_cnt runs only while a bus reset is pending and restarts from zero
  always_ff @(posedge sys_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      node_address <= `BPA_NODE_RST;
      driver_inhibit <= 1'b0;
      bus_reset_request <= 1'b0;
      node_priority <= `BPA_PRIO_RST;
      reset_cnt <= 8'h00;
    end else begin
      if (wr_node) node_address <= wr_data[5:0];
      if (wr_ctrl) driver_inhibit <= wr_data[`BPA_CTRL_INHIBIT_BIT];
      if (wr_prio) node_priority <= wr_data[3:0];
      bus_reset_request <= next_reset_req;
      reset_cnt <= (bus_reset_request && !reset_done) ? reset_cnt + 8'h01 : 8'h00;
    end
  end

  // read mux; reserved bits and addresses return zero
  wire [7:0] rd_word = (rd_addr == `BPA_ADDR_NODE) ? {2'b00, node_address} :
                       (rd_addr == `BPA_ADDR_CTRL) ? {6'h00, bus_reset_request, driver_inhibit} :
                       (rd_addr == `BPA_ADDR_PRIO) ? {4'h0, node_priority} : 8'h00;

  // read answer: one-cycle valid pulse, address and data held until the next read
  always_ff @(posedge sys_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      read_valid_out <= 1'b0;
      read_addr_out <= 4'h0;
      read_data_out <= 8'h00;
    end else begin
      read_valid_out <= rd_stb;
      if (rd_stb) begin
        read_addr_out <= rd_addr;
        read_data_out <= rd_word;
      end
    end
  end

  // ************************************************************
  // arbitration
  // ************************************************************
  // pin priority comes through the synchronisers, so a pin change counts two clocks late
  // a bus request that arrives while contention runs is ignored by the arbiter
  wire [3:0] eff_prio = psel_sync ? pval_sync : node_priority;
  wire arb_start = stop_ok && !is_read && !is_write;

  bpa_arbiter u_arb (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_sync),
    .start_in(arb_start),
    .prio_in(eff_prio),
    .node_in(node_address),
    .bus_sense_in(sense_sync),
    .drive_out(bus_drive_out),
    .busy_out(arb_busy_out),
    .won_out(arb_won_out),
    .lost_out(arb_lost_out)
  );

  // ************************************************************
  // data-strobe encoder
  // ************************************************************
  logic ds_phase;
  logic ds_data, ds_strobe;

  // a bit offered on the wrong phase is not taken; the source holds it two clocks
  // one symbol per two clocks; strobe flips only when data does not
  always_ff @(posedge sys_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      ds_phase <= 1'b0;
      ds_data <= 1'b0;
      ds_strobe <= 1'b0;
    end else begin
      ds_phase <= ~ds_phase;
      if (ds_phase && tx_valid_in) begin
        ds_data <= tx_bit_in;
        if (tx_bit_in == ds_data) ds_strobe <= ~ds_strobe;
      end
    end
  end

  assign tx_serial_data_out = ds_data;
  assign tx_serial_strobe_out = ds_strobe;
  assign tx_driver_en_out = !driver_inhibit;
  assign bus_reset_active_out = bus_reset_request;

  // ************************************************************
  // register, encoder and priority checks
  // ************************************************************
  node_reset_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    $rose(rst_sync) |-> (node_address == 6'h00)) else $error("node address not zero");
  node_write_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    wr_node |=> (node_address == $past(wr_data[5:0]))) else $error("node address not written");
  inhibit_off_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    (wr_ctrl && wr_data[`BPA_CTRL_INHIBIT_BIT]) |=> !tx_driver_en_out)
    else $error("drivers on while inhibited");
  inhibit_clear_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    (wr_ctrl && !wr_data[`BPA_CTRL_INHIBIT_BIT]) |=> tx_driver_en_out)
    else $error("drivers off while enabled");
  reset_clear_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    (reset_done && !wr_ctrl) |=> !bus_reset_request) else $error("reset request stuck");
  reset_len_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    $rose(bus_reset_request) |-> ##39 reset_done) else $error("bus reset length wrong");
  prio_write_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    wr_prio |=> (node_priority == $past(wr_data[3:0]))) else $error("priority not written");
  reg_prio_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    (arb_start && !arb_busy_out && !psel_sync) |=> (bus_drive_out == $past(node_priority[3])))
    else $error("register priority not sent");
  node_read_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    (rd_stb && rd_addr == `BPA_ADDR_NODE) |=> (read_data_out == {2'b00, $past(node_address)}))
    else $error("node address read wrong");
  ds_rate_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    $changed(tx_serial_data_out) |=> $stable(tx_serial_data_out)) else $error("data too fast");
  ds_strobe_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    $changed(tx_serial_strobe_out) |=> $stable(tx_serial_strobe_out)) else $error("strobe too fast");
  ds_one_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    $changed(tx_serial_strobe_out) |-> $stable(tx_serial_data_out)) else $error("data and strobe moved together");
  pin_prio_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    (arb_start && !arb_busy_out && psel_sync) |=> (bus_drive_out == $past(pval_sync[3])))
    else $error("pin priority ignored");
  start_busy_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    (arb_start && !arb_busy_out) |=> arb_busy_out) else $error("bus request did not start arbitration");
  rsvd_read_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    (rd_stb && rd_addr == `BPA_ADDR_RSVD) |=> (read_data_out == 8'h00))
    else $error("reserved not zero");
  rsvd_write_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    (wr_stb && wr_addr == `BPA_ADDR_RSVD) |=> ($stable(node_address) && $stable(node_priority)))
    else $error("reserved write took effect");

  // ************************************************************
  // request receiver checks
  // ************************************************************
  read_len_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    rd_stb |-> (req_cnt == 5'h08)) else $error("read frame length wrong");
  write_len_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    wr_stb |-> (req_cnt == 5'h10)) else $error("write frame length wrong");
  bad_stop_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    (frame_end && link_request_line_sync) |=> (!read_valid_out && $stable(node_address) && $stable(node_priority)))
    else $error("frame with bad stop bit acted on");
  read_pulse_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    read_valid_out |=> !read_valid_out) else $error("read valid longer than one cycle");
  read_addr_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    rd_stb |=> (read_addr_out == $past(rd_addr))) else $error("read address not returned");
endmodule

/* File: verif/bpa_node_model.sv */
`timescale 1ns/100ps
// ****************************************
// another node arbitrating on the backplane
// ****************************************
module bpa_node_model (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic arb_in,
  input wire logic [9:0] code_in,
  input wire logic bus_in,
  output logic drive_out
);
  logic [5:0] cnt;
  logic alive;
  wire logic my_bit = code_in[4'd9 - cnt[5:2]];
  // 1 asserts the wired-or bus, 0 releases it; code msb first, 4 clocks a bit
  assign drive_out = arb_in & alive & my_bit;
  // withdraw at the end of a period when the bus differs from the own bit
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= 6'h00;
      alive <= 1'b1;
    end else if (!arb_in) begin
      cnt <= 6'h00;
      alive <= 1'b1;
    end else begin
      if (cnt != 6'h27) cnt <= cnt + 6'h01;
      if (cnt[1:0] == 2'h3 && bus_in != my_bit) alive <= 1'b0;
    end
  end
endmodule

/* File: verif/tb_backplane_phy_arbitration_regs.sv */
`timescale 1ns/100ps
// ****************************************
// register and arbitration bench
// ****************************************
module tb_backplane_phy_arbitration_regs;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic line = 1'b0;
  logic psel = 1'b0;
  logic [3:0] pval = 4'h0;
  logic txv = 1'b0;
  logic txb = 1'b0;
  logic [9:0] mcode = 10'h000;
  logic pd = 1'b0;
  logic ps = 1'b0;
  logic [1:0] tl = 2'h0;
  logic dbad = 1'b0;
  logic rv, bd, td, ts, ten, bra, busy, won, lost, md;
  logic [3:0] ra;
  logic [7:0] rd;
  int err_count = 0;
  int checks_done = 0;
  int tg = 0;
  wire logic bus = bd | md;
  bpa_phy_regs i_dut (.sys_clk_in(clk), .rst_n_in(rst_n), .link_request_line_in(line),
    .read_valid_out(rv), .read_addr_out(ra), .read_data_out(rd), .pin_priority_select_in(psel),
    .pin_priority_value_in(pval), .tx_valid_in(txv), .tx_bit_in(txb), .bus_sense_in(bus),
    .bus_drive_out(bd), .tx_serial_data_out(td), .tx_serial_strobe_out(ts),
    .tx_driver_en_out(ten), .bus_reset_active_out(bra), .arb_busy_out(busy),
    .arb_won_out(won), .arb_lost_out(lost));
  bpa_node_model i_node (.sys_clk_in(clk), .rst_n_in(rst_n), .arb_in(busy), .code_in(mcode),
    .bus_in(bus), .drive_out(md));
  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end
  // flags a data or strobe line that changes on two clocks in a row
  always @(posedge clk) begin
    pd <= td;
    ps <= ts;
    tl <= {td !== pd, ts !== ps};
    if (rst_n && |({td !== pd, ts !== ps} & tl)) dbad <= 1'b1;
    if (rst_n && (td !== pd || ts !== ps)) tg <= tg + 1;
  end
  // verdict and end of run
  task automatic complete_run();
    if (err_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // compare one value
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // bounded wait for a level
  task automatic wait_for(ref logic s, input logic v, input int n);
    for (int i = 0; i < n && s !== v; i++) @(posedge clk) #1;
    chk("wait", {7'h00, v}, {7'h00, s});
    if (s !== v) complete_run();
  endtask
  // shift a frame out on the request line, msb first, one bit a clock
  task automatic send(input logic [16:0] f, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk);
      line <= f[i];
    end
    @(posedge clk);
    line <= 1'b0;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    send({1'b1, 3'h5, a, d, 1'b0}, 17);
    repeat (6) @(posedge clk);
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
    send({8'h00, 1'b1, 3'h1, a, 1'b0}, 9);
    wait_for(rv, 1'b1, 20);
    chk("raddr", {4'h0, a}, {4'h0, ra});
    chk("rdata", exp, rd);
  endtask
  task automatic bus_req();
    send({6'h00, 1'b1, 3'h0, 6'h00, 1'b0}, 11);
  endtask
  // values after reset
  task automatic t_reset();
    reg_rd(4'h0, 8'h00);
    reg_rd(4'h1, 8'h00);
    reg_rd(4'h3, 8'h00);
    reg_rd(4'h4, 8'h00);
    chk("drv_en", 8'h01, {7'h00, ten});
  endtask
  // field widths, placement and reserved bits
  task automatic t_fields();
    reg_wr(4'h0, 8'hFF);
    reg_rd(4'h0, 8'h3F);
    reg_rd(4'h4, 8'h00);
    reg_wr(4'h3, 8'hFF);
    reg_rd(4'h3, 8'h00);
    reg_wr(4'h1, 8'hFC);
    reg_rd(4'h1, 8'h00);
    reg_wr(4'h4, 8'hFF);
    reg_rd(4'h4, 8'h0F);
    reg_wr(4'h4, 8'h00);
  endtask
  // driver inhibit on and off
  task automatic t_inhibit();
    reg_wr(4'h1, 8'h01);
    chk("drv_en", 8'h00, {7'h00, ten});
    reg_rd(4'h1, 8'h01);
    reg_wr(4'h1, 8'h00);
    chk("drv_en", 8'h01, {7'h00, ten});
  endtask
  // bus reset request clears itself
  task automatic t_busreset();
    reg_wr(4'h1, 8'h02);
    chk("rst_act", 8'h01, {7'h00, bra});
    reg_rd(4'h1, 8'h02);
    wait_for(bra, 1'b0, 60);
    reg_rd(4'h1, 8'h00);
  endtask
  // write frame with a bad stop bit is ignored
  task automatic t_refused();
    send({1'b1, 3'h5, 4'h0, 8'h15, 1'b1}, 17);
    repeat (6) @(posedge clk);
    reg_rd(4'h0, 8'h3F);
  endtask
  // lone node, priority 0 node 1: nine zeros then a one
  task automatic t_arb_win();
    reg_wr(4'h0, 8'h01);
    mcode <= 10'h000;
    bus_req();
    wait_for(busy, 1'b1, 30);
    repeat (2) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      chk("drive", {7'h00, i == 9}, {7'h00, bd});
      repeat (4) @(posedge clk);
    end
    wait_for(won, 1'b1, 20);
    chk("lost", 8'h00, {7'h00, lost});
  endtask
  // higher priority node outbids on the first bit
  task automatic t_arb_lose();
    mcode <= {4'h8, 6'h00};
    bus_req();
    wait_for(lost, 1'b1, 60);
    chk("won", 8'h00, {7'h00, won});
    chk("drive", 8'h00, {7'h00, bd});
  endtask
  // pin priority beats the register value
  task automatic t_pin_prio();
    psel <= 1'b1;
    pval <= 4'hF;
    mcode <= {4'h7, 6'h3F};
    bus_req();
    wait_for(won, 1'b1, 60);
    chk("lost", 8'h00, {7'h00, lost});
    psel <= 1'b0;
  endtask
  // data/strobe encoder fed every clock
  task automatic t_ds();
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      txv <= 1'b1;
      txb <= i[1];
    end
    @(posedge clk);
    txv <= 1'b0;
    repeat (4) @(posedge clk);
    chk("ds_fast", 8'h00, {7'h00, dbad});
    chk("ds_moves", 8'h01, {7'h00, tg > 0});
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_fields();
    t_inhibit();
    t_busreset();
    t_refused();
    t_arb_win();
    t_arb_lose();
    t_pin_prio();
    t_ds();
    complete_run();
  end
endmodule
